// file: design/aspc_top.sv
// Asynchronous serial port with APB register access.
// Behaviour
// - Receive polarity bit selects line idle level.
// - High speed: 4 ticks per bit, else 16.
// - Two bits pick data width and parity.
// - Stop select sends two stop bits.
// - Transmit event mode chooses event cause.
// - Transmit polarity, reversed when infrared is on.
// - Break sends start, twelve zeros, stop.
// - Transmit disable aborts, flushes, releases pin.
// - Full flag when no transmit slot free.
// - Done flag when shifter and queue empty.
// - Receive event mode sets fill threshold.
// - Address detect only in nine-bit mode.
// - Idle flag reads one while receiver idle.
// - Parity flag belongs to head character.
// - Framing flag belongs to head character.
// - Overrun set by hardware, clear flushes receiver.
// - Data available while receive queue nonempty.
// - Wake on start edge while asleep.
// - Loopback routes transmitter into receiver.
// - Infrared coding only at 16x rate.
// - Both queues hold four characters.
//
// Our own choices: the APB register port and the register addresses.
`include "aspc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module aspc_top #(
  parameter int FIFO_DEPTH = `ASPC_FIFO_DEPTH
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  input wire logic I_RX,
  input wire logic I_SLEEP,
  output logic O_TX,
  output logic O_TX_OE,
  output logic O_TX_IRQ,
  output logic O_RX_IRQ,
  output logic O_WAKE_IRQ
);
  import aspc_pkg::*;
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL = CW'(FIFO_DEPTH);

  // The receive thresholds of three and four need at least four slots.
  if (FIFO_DEPTH < 4 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO_DEPTH must be a power of two of at least 4.");
  end

  function automatic logic has_par(input logic [1:0] pd);
    return pd == `ASPC_PD_8E || pd == `ASPC_PD_8O;
  endfunction

  function automatic logic [3:0] frame_bits(input logic [1:0] pd);
    return (pd == `ASPC_PD_9N || has_par(pd)) ? 4'd9 : 4'd8;
  endfunction

  logic [15:0] mode;
  logic [15:0] divisor;
  logic [1:0] tx_isel;
  logic tx_inv;
  logic brk;
  logic tx_en;
  logic [1:0] rx_isel;
  logic address_detect_enable;
  logic overrun_error_flag;
  logic setup;
  logic acc;
  logic wr;
  logic rd;

  logic [1:0] pd;
  logic hs;
  logic ir_on;
  logic [3:0] last_ph;
  assign pd = mode[`ASPC_M_PD_HI:`ASPC_M_PD_LO];
  assign hs = mode[`ASPC_M_HIGH_SPEED_BAUD_SELECT];
  assign ir_on = mode[`ASPC_M_INFRARED_CODEC_ENABLE] & ~hs;
  assign last_ph = hs ? `ASPC_TPB_HI : `ASPC_TPB_LO;

  assign setup = I_PSEL & ~I_PENABLE;
  assign acc = I_PSEL & I_PENABLE & O_PREADY;
  assign wr = acc & I_PWRITE;
  assign rd = acc & ~I_PWRITE;

  // Baud generator: one tick every divisor plus one clocks.
  logic [15:0] brg_cnt;
  logic tick;
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      brg_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (brg_cnt >= divisor) begin
      brg_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      brg_cnt <= brg_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // Transmit queue and shifter.
  logic [8:0] txq [FIFO_DEPTH];
  logic [PW-1:0] tx_rd;
  logic [PW-1:0] tx_wr;
  logic [CW-1:0] tx_cnt;
  logic [13:0] tx_sh;
  logic [3:0] tx_left;
  logic [3:0] tx_ph;
  logic tx_busy;
  logic tx_brk;
  logic tx_full;
  logic tx_push;
  logic tx_load;
  logic tx_pop;
  logic tx_end;
  logic tx_mark;
  logic [13:0] next_frame;
  logic [3:0] next_len;
  logic [8:0] tx_head;

  assign tx_full = tx_cnt == FULL;
  assign tx_push = wr && I_PADDR == `ASPC_A_TXDATA && tx_en && !tx_full;
  assign tx_load = tick & ~tx_busy & tx_en & (brk | tx_cnt != '0);
  assign tx_pop = tx_load & ~brk;
  assign tx_end = tick & tx_busy & tx_ph == last_ph & tx_left == 4'h1;
  assign tx_mark = tx_busy ? tx_sh[0] : 1'b1;
  assign tx_head = txq[tx_rd];

  always_comb begin
    if (brk) begin
      next_frame = 14'h2000;
      next_len = `ASPC_BRK_LEN;
    end else begin
      next_frame = {4'hf, 1'b1, tx_head[7:0], 1'b0};
      if (pd == `ASPC_PD_9N) begin
        next_frame[9] = tx_head[8];
      end else if (pd == `ASPC_PD_8E) begin
        next_frame[9] = ^tx_head[7:0];
      end else if (pd == `ASPC_PD_8O) begin
        next_frame[9] = ~^tx_head[7:0];
      end
      next_len = 4'h1 + frame_bits(pd) + (mode[`ASPC_M_STOP_BIT_SELECT] ? 4'h2 : 4'h1);
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (tx_push) begin
      txq[tx_wr] <= I_PWDATA[8:0];
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      tx_rd <= '0;
      tx_wr <= '0;
      tx_cnt <= '0;
    end else if (!tx_en) begin
      tx_rd <= '0;
      tx_wr <= '0;
      tx_cnt <= '0;
    end else begin
      tx_wr <= tx_wr + PW'(tx_push);
      tx_rd <= tx_rd + PW'(tx_pop);
      tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      tx_busy <= 1'b0;
      tx_brk <= 1'b0;
      tx_sh <= 14'h3fff;
      tx_left <= 4'h0;
      tx_ph <= 4'h0;
    end else if (!tx_en) begin
      tx_busy <= 1'b0;
      tx_brk <= 1'b0;
    end else if (tx_load) begin
      tx_busy <= 1'b1;
      tx_brk <= brk;
      tx_sh <= next_frame;
      tx_left <= next_len;
      tx_ph <= 4'h0;
    end else if (tick && tx_busy) begin
      tx_ph <= tx_ph + 4'h1;
      if (tx_ph == last_ph) begin
        tx_ph <= 4'h0;
        tx_sh <= {1'b1, tx_sh[13:1]};
        tx_left <= tx_left - 4'h1;
        tx_busy <= tx_left != 4'h1;
      end
    end
  end

  // Pin drive; in infrared mode a space is a short pulse off the idle level.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_TX <= 1'b1;
      O_TX_OE <= 1'b0;
    end else begin
      O_TX_OE <= tx_en;
      if (ir_on) begin
        O_TX <= (!tx_mark && tx_ph < `ASPC_IR_PULSE) ? ~tx_inv : tx_inv;
      end else begin
        O_TX <= tx_mark ^ tx_inv;
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_TX_IRQ <= 1'b0;
    end else begin
      unique case (tx_isel)
        `ASPC_TXI_EACH: O_TX_IRQ <= tx_pop;
        `ASPC_TXI_EMPTY: O_TX_IRQ <= tx_pop && tx_cnt == CW'(1);
        `ASPC_TXI_DONE: O_TX_IRQ <= tx_end && tx_cnt == '0;
        default: O_TX_IRQ <= 1'b0;
      endcase
    end
  end

  // Receive line selection and infrared pulse stretching.
  logic [3:0] ir_hold;
  logic ir_pulse;
  logic rx_src;
  logic rx_s;
  logic rx_p;
  assign ir_pulse = ~(I_RX ^ mode[`ASPC_M_RXINV]);
  always_comb begin
    if (mode[`ASPC_M_LOOP]) begin
      rx_src = tx_mark;
    end else if (ir_on) begin
      rx_src = ~ir_pulse & ir_hold == 4'h0;
    end else begin
      rx_src = I_RX ^ mode[`ASPC_M_RXINV];
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      ir_hold <= 4'h0;
      rx_s <= 1'b1;
      rx_p <= 1'b1;
    end else begin
      if (ir_pulse) begin
        ir_hold <= `ASPC_TPB_LO;
      end else if (tick && ir_hold != 4'h0) begin
        ir_hold <= ir_hold - 4'h1;
      end
      rx_s <= rx_src;
      rx_p <= rx_s;
    end
  end

  // Receiver state machine and queue.
  aspc_rx_state_t rx_st;
  logic [10:0] rx_sh;
  logic [3:0] rx_n;
  logic [3:0] rx_ph;
  logic rx_done;
  logic [10:0] rx_w;
  logic [10:0] rx_q [FIFO_DEPTH];
  logic [PW-1:0] rx_rd;
  logic [PW-1:0] rx_wr;
  logic [CW-1:0] rx_cnt;
  logic [10:0] rx_head;
  logic rx_parity_error_flag;
  logic rx_framing_error_flag;
  logic rx_keep;
  logic rx_push;
  logic rx_pop;
  logic rx_over;
  logic overrun_error_flag_clr;
  logic [CW-1:0] rx_new;

  assign rx_done = rx_st == RX_BITS && tick && rx_ph == last_ph
    && rx_n == 4'h1;
  // The last sample lands in the shifter at this very edge, so include it.
  assign rx_w = {rx_s, rx_sh[10:1]} >> (4'd10 - frame_bits(pd));
  assign rx_framing_error_flag = ~rx_w[frame_bits(pd)];
  assign rx_parity_error_flag = has_par(pd)
    && (rx_w[8] ^ ^rx_w[7:0] ^ (pd == `ASPC_PD_8O));
  assign rx_keep = !(pd == `ASPC_PD_9N && address_detect_enable && !rx_w[8]);
  assign rx_over = rx_done && rx_keep && rx_cnt == FULL && !rx_pop;
  assign rx_push = rx_done && rx_keep && !overrun_error_flag && !rx_over;
  assign rx_pop = rd && I_PADDR == `ASPC_A_RXDATA && rx_cnt != '0;
  assign overrun_error_flag_clr = wr && I_PADDR == `ASPC_A_STAT && overrun_error_flag
    && !I_PWDATA[`ASPC_S_OVERRUN_ERROR_FLAG] && !rx_over;
  assign rx_head = rx_cnt != '0 ? rx_q[rx_rd] : 11'h000;
  assign rx_new = rx_cnt - CW'(rx_pop) + CW'(1);

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      rx_st <= RX_IDLE;
      rx_sh <= 11'h000;
      rx_n <= 4'h0;
      rx_ph <= 4'h0;
    end else if (overrun_error_flag_clr) begin
      rx_st <= RX_IDLE;
      rx_sh <= 11'h000;
    end else begin
      unique case (rx_st)
        RX_IDLE: begin
          rx_ph <= 4'h0;
          if (!rx_s && !mode[`ASPC_M_AUTO_BAUD_ENABLE]) begin
            rx_st <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph == (hs ? `ASPC_MID_HI : `ASPC_MID_LO)) begin
              rx_ph <= 4'h0;
              rx_n <= frame_bits(pd) + 4'h1;
              rx_st <= rx_s ? RX_IDLE : RX_BITS;
            end
          end
        end
        RX_BITS: begin
          if (tick) begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph == last_ph) begin
              rx_ph <= 4'h0;
              rx_sh <= {rx_s, rx_sh[10:1]};
              rx_n <= rx_n - 4'h1;
              if (rx_n == 4'h1) begin
                rx_st <= RX_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (rx_push) begin
      rx_q[rx_wr] <= {rx_parity_error_flag, rx_framing_error_flag,
        pd == `ASPC_PD_9N ? rx_w[8] : 1'b0, rx_w[7:0]};
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      rx_rd <= '0;
      rx_wr <= '0;
      rx_cnt <= '0;
    end else if (overrun_error_flag_clr) begin
      rx_rd <= '0;
      rx_wr <= '0;
      rx_cnt <= '0;
    end else begin
      rx_wr <= rx_wr + PW'(rx_push);
      rx_rd <= rx_rd + PW'(rx_pop);
      rx_cnt <= rx_cnt + CW'(rx_push) - CW'(rx_pop);
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_RX_IRQ <= 1'b0;
    end else if (rx_isel == `ASPC_RXI_4) begin
      O_RX_IRQ <= rx_push && rx_new == CW'(4);
    end else if (rx_isel == `ASPC_RXI_3) begin
      O_RX_IRQ <= rx_push && rx_new == CW'(3);
    end else begin
      O_RX_IRQ <= rx_push;
    end
  end

  // Auto-baud: time the start bit of the sync character in clocks.
  logic ab_run;
  logic [19:0] ab_cnt;
  logic ab_done;
  logic [19:0] ab_div;
  assign ab_done = ab_run & rx_s;
  assign ab_div = (hs ? ab_cnt >> 2 : ab_cnt >> 4);
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      ab_run <= 1'b0;
      ab_cnt <= 20'h00000;
    end else if (!mode[`ASPC_M_AUTO_BAUD_ENABLE]) begin
      ab_run <= 1'b0;
    end else if (!ab_run && !rx_s && rx_p) begin
      ab_run <= 1'b1;
      ab_cnt <= 20'h00001;
    end else if (ab_run) begin
      ab_cnt <= ab_cnt + 20'h00001;
      ab_run <= !rx_s;
    end
  end

  // Wake: edge seen while asleep raises the event, next rise clears enable.
  logic wake_arm;
  logic wake_fall;
  logic wake_rise;
  assign wake_fall = I_SLEEP & mode[`ASPC_M_WAKE] & !wake_arm & !rx_s & rx_p;
  assign wake_rise = wake_arm & rx_s & !rx_p;
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      wake_arm <= 1'b0;
      O_WAKE_IRQ <= 1'b0;
    end else begin
      O_WAKE_IRQ <= wake_fall;
      if (wake_fall) begin
        wake_arm <= 1'b1;
      end else if (wake_rise) begin
        wake_arm <= 1'b0;
      end
    end
  end

  // Software registers; hardware clears lose to a software write.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      mode <= `ASPC_MODE_RST;
      divisor <= `ASPC_DIV_RST;
    end else if (wr && I_PADDR == `ASPC_A_MODE) begin
      mode <= I_PWDATA[15:0] & `ASPC_MODE_MASK;
    end else begin
      if (wr && I_PADDR == `ASPC_A_DIV) begin
        divisor <= I_PWDATA[15:0];
      end
      if (ab_done) begin
        divisor <= ab_div == '0 ? 16'h0000 : 16'(ab_div - 20'h00001);
        mode[`ASPC_M_AUTO_BAUD_ENABLE] <= 1'b0;
      end
      if (wake_rise) begin
        mode[`ASPC_M_WAKE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      tx_isel <= 2'h0;
      tx_inv <= 1'b0;
      brk <= 1'b0;
      tx_en <= 1'b0;
      rx_isel <= 2'h0;
      address_detect_enable <= 1'b0;
    end else if (wr && I_PADDR == `ASPC_A_STAT) begin
      tx_isel <= {I_PWDATA[15], I_PWDATA[13]};
      tx_inv <= I_PWDATA[14];
      brk <= I_PWDATA[11];
      tx_en <= I_PWDATA[10];
      rx_isel <= I_PWDATA[7:6];
      address_detect_enable <= I_PWDATA[5];
    end else if (tx_end && tx_brk) begin
      brk <= 1'b0;
    end
  end

  // Overrun: the set wins over a clear in the same cycle.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      overrun_error_flag <= 1'b0;
    end else if (rx_over) begin
      overrun_error_flag <= 1'b1;
    end else if (overrun_error_flag_clr) begin
      overrun_error_flag <= 1'b0;
    end
  end

  // APB answer is prepared in the setup cycle, so every access has no wait.
  logic [31:0] next_rdata;
  logic next_err;
  always_comb begin
    next_err = 1'b0;
    next_rdata = 32'h00000000;
    unique case (I_PADDR)
      `ASPC_A_MODE: next_rdata = {16'h0000, mode};
      `ASPC_A_STAT: next_rdata = {16'h0000, tx_isel[1], tx_inv, tx_isel[0],
        1'b0, brk, tx_en, tx_full, !tx_busy && tx_cnt == '0,
        rx_isel, address_detect_enable, rx_st == RX_IDLE,
        rx_head[10], rx_head[9], overrun_error_flag, rx_cnt != '0};
      `ASPC_A_RXDATA: next_rdata = {23'h000000, rx_head[8:0]};
      `ASPC_A_TXDATA, `ASPC_A_DIV: next_rdata = {16'h0000,
        I_PADDR == `ASPC_A_DIV ? divisor : 16'h0000};
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h00000000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= setup;
      O_PRDATA <= setup && !I_PWRITE ? next_rdata : 32'h00000000;
      O_PSLVERR <= setup && next_err;
    end
  end
endmodule // aspc_top
`default_nettype wire

// file: design/aspc_regs.svh
// Register map, field positions, reset values and codes of the serial port.
`ifndef ASPC_REGS_SVH
`define ASPC_REGS_SVH
`define ASPC_FIFO_DEPTH 4
`define ASPC_A_MODE 8'h00
`define ASPC_A_STAT 8'h04
`define ASPC_A_TXDATA 8'h08
`define ASPC_A_RXDATA 8'h0c
`define ASPC_A_DIV 8'h10
`define ASPC_M_INFRARED_CODEC_ENABLE 12
`define ASPC_M_WAKE 7
`define ASPC_M_LOOP 6
`define ASPC_M_AUTO_BAUD_ENABLE 5
`define ASPC_M_RXINV 4
`define ASPC_M_HIGH_SPEED_BAUD_SELECT 3
`define ASPC_M_PD_HI 2
`define ASPC_M_PD_LO 1
`define ASPC_M_STOP_BIT_SELECT 0
`define ASPC_MODE_MASK 16'h10ff
`define ASPC_MODE_RST 16'h0000
`define ASPC_DIV_RST 16'h0000
`define ASPC_S_OVERRUN_ERROR_FLAG 1
`define ASPC_PD_8N 2'h0
`define ASPC_PD_8E 2'h1
`define ASPC_PD_8O 2'h2
`define ASPC_PD_9N 2'h3
`define ASPC_TXI_EACH 2'h0
`define ASPC_TXI_DONE 2'h1
`define ASPC_TXI_EMPTY 2'h2
`define ASPC_RXI_3 2'h2
`define ASPC_RXI_4 2'h3
`define ASPC_TPB_HI 4'h3
`define ASPC_TPB_LO 4'hf
`define ASPC_MID_HI 4'h1
`define ASPC_MID_LO 4'h7
`define ASPC_IR_PULSE 4'h3
`define ASPC_BRK_LEN 4'he
`endif

// file: design/aspc_pkg.sv
// Types shared by the serial port design.
package aspc_pkg;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_BITS = 3'b100
  } aspc_rx_state_t;
endpackage

// file: test/aspc_top_sva.sv
// Checker for the serial port's bus answers, pin ownership and pulses.
`timescale 1ns/100ps
`default_nettype none
module aspc_top_sva #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic O_PREADY,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PSLVERR,
  input wire logic I_RX,
  input wire logic I_SLEEP,
  input wire logic O_TX,
  input wire logic O_TX_OE,
  input wire logic O_TX_IRQ,
  input wire logic O_RX_IRQ,
  input wire logic O_WAKE_IRQ
);
  // The break limit assumes divisor 0, 16x ticks and no inversion.
  localparam int BREAK_CLKS = 208;
  logic [8:0] low_run;
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  sequence s_setup;
    I_PSEL && !I_PENABLE;
  endsequence
  sequence s_write_stat;
    I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == 8'h04;
  endsequence
  // Saturating, so a stuck space line cannot wrap back under the limit.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      low_run <= 9'h000;
    end else if (!O_TX_OE || O_TX) begin
      low_run <= 9'h000;
    end else if (low_run != 9'h1ff) begin
      low_run <= low_run + 9'h001;
    end
  end
  a_pready_follows: assert property (s_setup |=> O_PREADY)
    else $error("ready missing after setup");
  a_pready_cause: assert property (O_PREADY |-> $past(I_PSEL && !I_PENABLE))
    else $error("ready without setup");
  a_pready_single: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held too long");
  a_slverr_unmapped: assert property (O_PREADY && I_PADDR > 8'h10 |-> O_PSLVERR)
    else $error("unmapped access not flagged");
  a_slverr_mapped: assert property
    (O_PREADY && I_PADDR <= 8'h10 && I_PADDR[1:0] == 2'h0 |-> !O_PSLVERR)
    else $error("mapped access flagged");
  a_prdata_quiet: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data outside access");
  a_txen_owns: assert property (s_write_stat ##0 I_PWDATA[10] |-> ##[1:2] O_TX_OE)
    else $error("pin not taken");
  a_txen_frees: assert property (s_write_stat ##0 !I_PWDATA[10] |-> ##[1:2] !O_TX_OE)
    else $error("pin not released");
  a_break_len: assert property (low_run <= BREAK_CLKS)
    else $error("space run too long");
  a_tx_irq_pulse: assert property (O_TX_IRQ |=> !O_TX_IRQ)
    else $error("transmit pulse too long");
  a_rx_irq_pulse: assert property (O_RX_IRQ |=> !O_RX_IRQ)
    else $error("receive pulse too long");
  a_wake_pulse: assert property (O_WAKE_IRQ |=> !O_WAKE_IRQ)
    else $error("wake pulse too long");
endmodule // aspc_top_sva
bind aspc_top aspc_top_sva #(.FIFO_DEPTH(FIFO_DEPTH)) aspc_top_sva_inst (
  .I_MCLK(I_MCLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR),
  .I_RX(I_RX), .I_SLEEP(I_SLEEP), .O_TX(O_TX), .O_TX_OE(O_TX_OE),
  .O_TX_IRQ(O_TX_IRQ), .O_RX_IRQ(O_RX_IRQ), .O_WAKE_IRQ(O_WAKE_IRQ));
`default_nettype wire

// file: test/aspc_remote.sv
// Remote serial node: sends frames on the receive line, decodes transmit.
`timescale 1ns/100ps
`default_nettype none
module aspc_remote #(
  parameter int BIT_CLKS = 16
) (
  input wire logic i_clk,
  input wire logic i_tx,
  input wire logic i_tx_oe,
  output logic o_rx
);
  logic [7:0] got = 8'h00;
  logic last_tx = 1'b1;
  int low_len = 0;
  int high_len = 0;
  int run = 0;
  initial o_rx = 1'b1;
  always @(posedge i_clk) begin
    if (i_tx_oe && i_tx !== last_tx) begin
      if (last_tx) begin
        high_len <= run;
      end else begin
        low_len <= run;
      end
      run <= 1;
    end else begin
      run <= run + 1;
    end
    last_tx <= i_tx;
  end
  // Decoding is fixed at 16 ticks; faster frames only feed the run lengths.
  initial begin
    forever begin
      @(posedge i_clk);
      if (i_tx_oe && i_tx === 1'b0) begin
        repeat (BIT_CLKS / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CLKS) @(posedge i_clk);
          got[i] = i_tx;
        end
        for (int n = 0; n < 512 && i_tx === 1'b0; n++) @(posedge i_clk);
      end
    end
  end
  // Start, n bits LSB first, then mark held two bit times.
  task automatic send(input logic [9:0] bits, input int n);
    o_rx <= 1'b0;
    repeat (BIT_CLKS) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_rx <= bits[i];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    o_rx <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge i_clk);
  endtask
endmodule // aspc_remote
`default_nettype wire

// file: test/aspc_top_bench.sv
// Self-checking bench: APB register tasks and serial scenarios.
`include "aspc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module aspc_top_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sleep = 1'b0;
  logic pready, pslverr, rx, tx, tx_oe, tx_irq, rx_irq, wake_irq, rerr;
  logic [31:0] prdata, rdata;
  logic [31:0] mode_v [3] = '{32'h0, 32'h1, 32'h8};
  logic [31:0] stat_v [3] = '{32'h0400, 32'h2400, 32'h8400};
  int bit_v [3] = '{16, 16, 4};
  int stop_v [3] = '{1, 2, 1};
  int irq_v [3] = '{2, 1, 2};
  int mismatches = 0;
  int cmp_count = 0;
  int tx_irqs = 0;
  int rx_irqs = 0;
  int wake_irqs = 0;
  initial forever #2.5 mclk = ~mclk;
  aspc_top aspc_top_inst (.I_MCLK(mclk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata),
    .O_PSLVERR(pslverr), .I_RX(rx), .I_SLEEP(sleep), .O_TX(tx),
    .O_TX_OE(tx_oe), .O_TX_IRQ(tx_irq), .O_RX_IRQ(rx_irq),
    .O_WAKE_IRQ(wake_irq));
  aspc_remote aspc_remote_inst (.i_clk(mclk), .i_tx(tx), .i_tx_oe(tx_oe),
    .o_rx(rx));
  always @(posedge mclk) begin
    if (tx_irq === 1'b1) tx_irqs++;
    if (rx_irq === 1'b1) rx_irqs++;
    if (wake_irq === 1'b1) wake_irqs++;
  end
  task automatic end_sim;
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until the edge that samples ready; data taken there.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (int n = 0; n < 16; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) begin
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        return;
      end
    end
    mismatches++;
    end_sim();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic wait_stat(input int b, input logic v);
    for (int n = 0; n < 400; n++) begin
      apb(1'b0, `ASPC_A_STAT, 32'h0);
      if (rdata[b] === v) return;
    end
    mismatches++;
    end_sim();
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(`ASPC_A_MODE, 32'h0);
    rd(`ASPC_A_STAT, 32'h0110);
    rd(8'h14, 32'h0);
    chk(rerr, 1'b1);
    wr(`ASPC_A_MODE, 32'hffff);
    rd(`ASPC_A_MODE, 32'h10ff);
    wr(`ASPC_A_MODE, 32'h0);
    $display("Test registers done");
    wr(`ASPC_A_STAT, 32'h0400);
    wr(`ASPC_A_TXDATA, 32'h41);
    chk(tx_oe, 1'b1);
    wait_stat(8, 1'b1);
    chk(aspc_remote_inst.got, 8'h41);
    $display("Test transmit done");
    for (int k = 0; k < 3; k++) begin
      wr(`ASPC_A_MODE, mode_v[k]);
      wr(`ASPC_A_STAT, stat_v[k]);
      tx_irqs = 0;
      wr(`ASPC_A_TXDATA, 32'h0);
      wr(`ASPC_A_TXDATA, 32'h0);
      wait_stat(8, 1'b1);
      chk(aspc_remote_inst.low_len, 9 * bit_v[k]);
      chk(aspc_remote_inst.high_len >= stop_v[k] * bit_v[k] &&
        aspc_remote_inst.high_len < (stop_v[k] + 1) * bit_v[k], 1'b1);
      chk(tx_irqs, irq_v[k]);
    end
    $display("Test frame shapes done");
    wr(`ASPC_A_MODE, 32'h0);
    wr(`ASPC_A_STAT, 32'h0c00);
    wait_stat(11, 1'b0);
    wait_stat(8, 1'b1);
    chk(aspc_remote_inst.low_len, 13 * 16);
    $display("Test break done");
    for (int i = 0; i < 5; i++) wr(`ASPC_A_TXDATA, i);
    rd(`ASPC_A_STAT, 32'h0610);
    wr(`ASPC_A_STAT, 32'h0);
    rd(`ASPC_A_STAT, 32'h0110);
    chk(tx_oe, 1'b0);
    $display("Test full and abort done");
    wr(`ASPC_A_MODE, 32'h2);
    aspc_remote_inst.send(10'h05a, 9);
    aspc_remote_inst.send(10'h15a, 9);
    rd(`ASPC_A_STAT, 32'h0111);
    rd(`ASPC_A_RXDATA, 32'h5a);
    rd(`ASPC_A_STAT, 32'h0119);
    rd(`ASPC_A_RXDATA, 32'h5a);
    rd(`ASPC_A_STAT, 32'h0110);
    wr(`ASPC_A_MODE, 32'h0);
    aspc_remote_inst.send(10'h0a5, 9);
    rd(`ASPC_A_STAT, 32'h0115);
    rd(`ASPC_A_RXDATA, 32'ha5);
    $display("Test receive errors done");
    wr(`ASPC_A_STAT, 32'h0080);
    rx_irqs = 0;
    for (int i = 0; i < 3; i++) aspc_remote_inst.send(10'h030 + i, 8);
    chk(rx_irqs, 1);
    for (int i = 0; i < 3; i++) aspc_remote_inst.send(10'h040 + i, 8);
    rd(`ASPC_A_STAT, 32'h0193);
    wr(`ASPC_A_STAT, 32'h0080);
    rd(`ASPC_A_STAT, 32'h0190);
    rd(`ASPC_A_RXDATA, 32'h0);
    $display("Test overrun done");
    wr(`ASPC_A_STAT, 32'h0400);
    wr(`ASPC_A_MODE, 32'h40);
    wr(`ASPC_A_TXDATA, 32'h33);
    wait_stat(0, 1'b1);
    rd(`ASPC_A_RXDATA, 32'h33);
    wr(`ASPC_A_MODE, 32'h0);
    $display("Test loopback done");
    sleep <= 1'b1;
    wr(`ASPC_A_MODE, 32'h80);
    aspc_remote_inst.send(10'h0ff, 8);
    chk(wake_irqs, 1);
    rd(`ASPC_A_MODE, 32'h0);
    sleep <= 1'b0;
    $display("Test wake done");
    wr(`ASPC_A_DIV, 32'h5);
    wr(`ASPC_A_MODE, 32'h20);
    aspc_remote_inst.send(10'h055, 8);
    rd(`ASPC_A_MODE, 32'h0);
    rd(`ASPC_A_DIV, 32'h0);
    $display("Test auto-baud done");
    end_sim();
  end
endmodule // aspc_top_bench
`default_nettype wire
